// >>> tb/sipp_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module sipp_mac_model (
  input  wire logic                CLK,
  input  wire logic                rst_n,
  input  wire logic                req,
  input  wire sipp_pkg::sipp_pkt_s req_pkt,
  input  wire logic [15:0]         req_used,
  output logic                     pkt_valid,
  output sipp_pkg::sipp_pkt_s      pkt,
  output logic [15:0]              bc_used
);
  import sipp_pkg::*;
  // engine supplies fields
  // Priority arrives already derived and override comes from the table entry.
  // Between pulses the descriptor toggles so a late sample cannot match.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pkt_valid <= 1'b0;
      pkt       <= '0;
      bc_used   <= 16'h0000;
    end else begin
      pkt_valid <= req;
      pkt       <= req ? req_pkt : ~pkt;
      bc_used   <= req_used;
    end
  end
endmodule
`default_nettype wire

// >>> tb/switch_ingress_port_policing_bench.sv
`include "sipp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module switch_ingress_port_policing_bench;
  import sipp_pkg::*;
  localparam int THR = 2000;
  logic          CLK, RESETN, req, pv, awv, awr, wv, wrd, bv, br;
  logic          arv, arr, rv, rr, vv, got;
  sipp_pkt_s     req_pkt, pk;
  sipp_verdict_s vd, v;
  logic [15:0]   req_used, used;
  logic [7:0]    awa, ara;
  logic [31:0]   wd, rdat, rd_val, seed;
  logic [1:0]    bresp, rresp, b_got, st;
  int            failures, checks, cyc, s, o;

  sipp_mac_model u_mac (.CLK(CLK), .rst_n(RESETN), .req(req),
    .req_pkt(req_pkt), .req_used(req_used), .pkt_valid(pv), .pkt(pk),
    .bc_used(used));
  sipp_top #(.THROT_CYC(THR)) u_dut (.CLK(CLK), .RESETN(RESETN),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrd), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .PKT_VALID(pv), .PKT(pk),
    .BC_BUF_USED(used), .VERDICT_VALID(vv), .VERDICT(vd));

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ready is sampled at the falling edge, where it has settled for the
  // coming rising edge that actually moves the item.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ap, dp, bp;
    @(posedge CLK);
    ap = 1'b1;
    dp = 1'b1;
    bp = 1'b1;
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    br <= 1'b1;
    while (bp) begin
      @(negedge CLK);
      if (bv) begin
        b_got = bresp;
        bp = 1'b0;
      end
      ap = ap && !awr;
      dp = dp && !wrd;
      @(posedge CLK);
      if (!ap) awv <= 1'b0;
      if (!dp) wv <= 1'b0;
      if (!bp) br <= 1'b0;
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic ap, rp;
    @(posedge CLK);
    ap = 1'b1;
    rp = 1'b1;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    while (rp) begin
      @(negedge CLK);
      if (rv) begin
        rd_val = rdat;
        rp = 1'b0;
      end
      ap = ap && !arr;
      @(posedge CLK);
      if (!ap) arv <= 1'b0;
      if (!rp) rr <= 1'b0;
    end
  endtask

  task automatic mset(input logic [4:0] n, input logic [1:0] t,
                      input logic [15:0] val);
    wr(`SIPP_OFF_MVAL, {16'h0000, val});
    wr(`SIPP_OFF_MCMD, {22'h000000, t, 3'h0, n});
  endtask

  task automatic send(input logic [1:0] p, input logic [2:0] q,
                      input logic [11:0] n, input logic f, input logic ov,
                      input logic [2:0] d, input logic [15:0] u);
    @(posedge CLK);
    req <= 1'b1;
    req_pkt <= '{p, q, n, f, ov, d};
    req_used <= u;
    got = 1'b0;
    @(posedge CLK);
    req <= 1'b0;
    repeat (4) begin
      @(negedge CLK);
      if (vv === 1'b1 && !got) begin
        v = vd;
        got = 1'b1;
      end
    end
    check(got, 1'b1);
  endtask

  function automatic logic pass(input logic [1:0] t, input logic ov);
    return t == `SIPP_ST_FWD || (ov && t != `SIPP_ST_DIS);
  endfunction

  initial begin
    seed = 32'h6663;
    RESETN = 1'b0;
    {req, awv, wv, br, arv, rr} = '0;
    req_pkt = '0;
    req_used = 16'h0000;
    {awa, ara, wd} = '0;
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK);
    rd(`SIPP_OFF_BUFLIM);
    check(rd_val[15:0], `SIPP_BUFLIM_RST);
    wr(8'h1C, 32'h0000_0001);
    check(b_got, 2'b10);
    for (s = 0; s < 4; s++) begin
      for (o = 0; o < 2; o++) begin
        st = s[1:0];
        wr(`SIPP_OFF_TREE, {26'h0, st, st, 2'h0});
        send(2'd1, 3'($random(seed)), 12'($random(seed)), 1'b0, o[0],
             3'b101, 16'($random(seed)));
        check(v.fwd, pass(st, o[0]));
        check(v.learn, st == `SIPP_ST_FWD || st == `SIPP_ST_LRN);
        check(v.colour, SIPP_UNMET);
        if (pass(st, o[0])) check(v.dest, {pass(st, o[0]), 2'b01});
        wr(`SIPP_OFF_TREE, {26'h0, st, 4'h0});
        send(2'd0, 3'($random(seed)), 12'($random(seed)), 1'b0, o[0],
             3'b110, 16'($random(seed)));
        check(v.dest, {pass(st, o[0]), 2'b10});
      end
    end
    wr(`SIPP_OFF_TREE, 32'h0000_0000);
    wr(`SIPP_OFF_BUFLIM, 32'h0000_000A);
    send(2'd0, 3'd0, 12'd64, 1'b1, 1'b0, 3'b110, 16'h000B);
    check(v.fwd, 1'b0);
    send(2'd0, 3'd0, 12'd64, 1'b1, 1'b0, 3'b110, 16'h000A);
    check(v.fwd, 1'b1);
    send(2'd0, 3'd0, 12'd64, 1'b0, 1'b0, 3'b110, 16'hFFFF);
    check(v.fwd, 1'b1);
    // Four tree-state drops and one buffer-level drop so far, meter off.
    rd(`SIPP_OFF_STATUS);
    check(rd_val[17:0], 18'h0_0005);
    wr(`SIPP_OFF_BUFLIM, 32'h0000_FFFF);
    wr(`SIPP_OFF_MCFG, 32'h0000_0001);
    mset(5'd1, `SIPP_TGT_CIR, 16'h1FFF);
    send(2'd1, 3'd0, 12'd1000, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_GREEN);
    send(2'd1, 3'd0, 12'd1000, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_YELLOW);
    send(2'd1, 3'd0, 12'd1000, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_RED);
    check(v.fwd, 1'b0);
    rd(`SIPP_OFF_STATUS);
    check(rd_val[17:16], 2'd3);
    send(2'd1, 3'd0, 12'd536, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_GREEN);
    for (s = 0; s < 3; s++) begin
      send(2'd2, 3'd0, 12'd1536, 1'b0, 1'b0, 3'b001, 16'h0000);
    end
    check(v.colour, SIPP_RED);
    repeat (800) @(posedge CLK);
    send(2'd2, 3'd0, 12'd150, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_GREEN);
    send(2'd2, 3'd0, 12'd150, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_RED);
    wr(`SIPP_OFF_MCFG, 32'h0000_0003);
    send(2'd0, 3'd1, 12'd600, 1'b0, 1'b0, 3'b010, 16'h0000);
    check(v.colour, SIPP_RED);
    send(2'd1, 3'd5, 12'd600, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_GREEN);
    wr(`SIPP_OFF_MCFG, 32'h0000_0005);
    send(2'd0, 3'd1, 12'd600, 1'b0, 1'b0, 3'b010, 16'h0000);
    check(v.colour, SIPP_RED);
    send(2'd2, 3'd1, 12'd600, 1'b0, 1'b0, 3'b001, 16'h0000);
    check(v.colour, SIPP_GREEN);
    mset(5'd0, `SIPP_TGT_CBS, 16'd100);
    send(2'd0, 3'd3, 12'd1200, 1'b0, 1'b0, 3'b010, 16'h0000);
    check(v.colour, SIPP_GREEN);
    wr(`SIPP_OFF_MCFG, 32'h0000_0000);
    send(2'd0, 3'd1, 12'd600, 1'b0, 1'b0, 3'b010, 16'h0000);
    check(v.colour, SIPP_UNMET);
    wr(`SIPP_OFF_THROT, 32'h0000_0202);
    send(2'd1, 3'd0, 12'd129, 1'b1, 1'b0, 3'b001, 16'h0000);
    check(v.fwd, 1'b0);
    send(2'd1, 3'd0, 12'd128, 1'b1, 1'b0, 3'b001, 16'h0000);
    check(v.fwd, 1'b1);
    send(2'd1, 3'd0, 12'd1, 1'b1, 1'b0, 3'b001, 16'h0000);
    check(v.fwd, 1'b0);
    send(2'd2, 3'd0, 12'd500, 1'b1, 1'b0, 3'b001, 16'h0000);
    check(v.fwd, 1'b1);
    repeat (THR) @(posedge CLK);
    send(2'd1, 3'd0, 12'd128, 1'b1, 1'b0, 3'b001, 16'h0000);
    check(v.fwd, 1'b1);
    results();
  end
endmodule
`default_nettype wire

// >>> verilog/sipp_pkg.sv
package sipp_pkg;

  typedef enum logic [1:0] {
    SIPP_UNMET,
    SIPP_GREEN,
    SIPP_YELLOW,
    SIPP_RED
  } sipp_colour_e;

  typedef struct packed {
    logic [1:0]  port;
    logic [2:0]  prio;
    logic [11:0] len;
    logic        flood;
    logic        ovr;
    logic [2:0]  dest;
  } sipp_pkt_s;

  typedef struct packed {
    logic         fwd;
    sipp_colour_e colour;
    logic [2:0]   dest;
    logic         learn;
  } sipp_verdict_s;

endpackage

// >>> verilog/sipp_regs.svh
`ifndef SIPP_REGS_SVH
`define SIPP_REGS_SVH

// Register byte offsets on the AXI4-Lite slave.
`define SIPP_OFF_TREE    8'h00
`define SIPP_OFF_MCFG    8'h04
`define SIPP_OFF_MCMD    8'h08
`define SIPP_OFF_MVAL    8'h0C
`define SIPP_OFF_THROT   8'h10
`define SIPP_OFF_BUFLIM  8'h14
`define SIPP_OFF_STATUS  8'h18

// Spanning tree state codes, two bits per port.
`define SIPP_ST_FWD      2'h0
`define SIPP_ST_BLK      2'h1
`define SIPP_ST_LRN      2'h2
`define SIPP_ST_DIS      2'h3

// Meter configuration and command fields.
`define SIPP_MCFG_EN     0
`define SIPP_MCFG_MODE   2:1
`define SIPP_MCMD_IDX    4:0
`define SIPP_MCMD_TGT    9:8
`define SIPP_TGT_CIR     2'h0
`define SIPP_TGT_CBS     2'h1
`define SIPP_TGT_EBS     2'h2
`define SIPP_MODE_PORT   2'h0
`define SIPP_MODE_PRIO   2'h1

// Broadcast throttle fields.
`define SIPP_THR_LEVEL   7:0
`define SIPP_THR_EN      10:8

// Reset values.
`define SIPP_BUCKET_INIT 16'h0600
`define SIPP_BUFLIM_RST  16'hFFFF
`define SIPP_LFSR_SEED   16'hACE1

// Timing and scaling.
`define SIPP_CLK_NS      20
`define SIPP_CIR_STEP_NS 20
`define SIPP_CIR_MIN_NS  80
`define SIPP_THROT_NS    1720000
`define SIPP_THR_SHIFT   6
`define SIPP_NUM_PORTS   3
`define SIPP_NUM_STREAMS 24

`endif

// >>> verilog/sipp_top.sv
`include "sipp_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module sipp_top #(
  parameter int unsigned THROT_CYC = `SIPP_THROT_NS / `SIPP_CLK_NS
) (
  input  wire logic                CLK,
  input  wire logic                RESETN,
  input  wire logic [7:0]          S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [7:0]          S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY,
  input  wire logic                PKT_VALID,
  input  wire sipp_pkg::sipp_pkt_s PKT,
  input  wire logic [15:0]         BC_BUF_USED,
  output logic                     VERDICT_VALID,
  output sipp_pkg::sipp_verdict_s  VERDICT
);
  import sipp_pkg::*;

  localparam int NP = `SIPP_NUM_PORTS;
  localparam int NS = `SIPP_NUM_STREAMS;
  localparam logic [13:0] STEP_CYC =
    14'(`SIPP_CIR_STEP_NS / `SIPP_CLK_NS);
  localparam logic [13:0] MIN_CYC =
    14'(`SIPP_CIR_MIN_NS / `SIPP_CLK_NS);

  logic        rst_q;
  logic        rst_n;
  logic        aw_held;
  logic [7:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_err;
  logic [31:0] rd_data;
  logic        rd_err;
  logic [5:0]  tree_ctl;
  logic [2:0]  mcfg;
  logic [9:0]  mcmd;
  logic [15:0] mval;
  logic [10:0] throt;
  logic [15:0] buflim;
  logic [15:0] cbs;
  logic [15:0] ebs;
  logic [15:0] drop_cnt;
  logic [12:0] cir   [NS];
  logic [13:0] pcnt  [NS];
  logic        tick  [NS];
  logic [15:0] cbk   [NS];
  logic [15:0] ebk   [NS];
  logic [15:0] next_cbk [NS];
  logic [15:0] next_ebk [NS];
  logic [15:0] bcnt  [NP];
  logic [16:0] ivl;
  logic [15:0] lfsr;
  logic [1:0]  st_src;
  logic [4:0]  sid;
  logic [15:0] need;
  logic        rx_ok;
  logic        meter_on;
  logic        deb_c;
  logic        deb_e;
  logic        ydrop;
  logic        bdrop;
  logic        bufdrop;
  logic [2:0]  dis_mask;
  sipp_verdict_s next_vd;

  // Reset is released through two flops so that it leaves cleanly.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q <= 1'b1;
      rst_n <= rst_q;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [13:0] period(input logic [12:0] c);
    logic [13:0] p;
    p = ({1'b0, c} + 14'h0001) * STEP_CYC;
    return (p < MIN_CYC) ? MIN_CYC : p;
  endfunction

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign wr_err = !(aw_addr inside {`SIPP_OFF_TREE, `SIPP_OFF_MCFG,
                    `SIPP_OFF_MCMD, `SIPP_OFF_MVAL, `SIPP_OFF_THROT,
                    `SIPP_OFF_BUFLIM, `SIPP_OFF_STATUS});

  // Address and data may arrive in either order; each is held until both.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= {S_AXI_AWADDR[7:2], 2'h0};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_err ? 2'h2 : 2'h0;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case ({S_AXI_ARADDR[7:2], 2'h0})
      `SIPP_OFF_TREE:   rd_data[5:0]  = tree_ctl;
      `SIPP_OFF_MCFG:   rd_data[2:0]  = mcfg;
      `SIPP_OFF_MCMD:   rd_data[9:0]  = mcmd;
      `SIPP_OFF_MVAL:   rd_data[15:0] = mval;
      `SIPP_OFF_THROT:  rd_data[10:0] = throt;
      `SIPP_OFF_BUFLIM: rd_data[15:0] = buflim;
      `SIPP_OFF_STATUS: rd_data[17:0] = {VERDICT.colour, drop_cnt};
      default:          rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_data;
      S_AXI_RRESP  <= rd_err ? 2'h2 : 2'h0;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // A write to the command register also writes the selected CIR table entry, or the shared CBS or EBS value.
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tree_ctl <= 6'h00;
      mcfg     <= 3'h0;
      mcmd     <= 10'h000;
      mval     <= 16'h0000;
      throt    <= 11'h000;
      buflim   <= `SIPP_BUFLIM_RST;
      cbs      <= `SIPP_BUCKET_INIT;
      ebs      <= `SIPP_BUCKET_INIT;
      for (int i = 0; i < NS; i++) begin
        cir[i] <= 13'h0000;
      end
    end else if (wr_fire) begin
      case (aw_addr)
        `SIPP_OFF_TREE:   tree_ctl <= 6'(merge(32'(tree_ctl), w_data, w_strb));
        `SIPP_OFF_MCFG:   mcfg <= 3'(merge(32'(mcfg), w_data, w_strb));
        `SIPP_OFF_MVAL:   mval <= 16'(merge(32'(mval), w_data, w_strb));
        `SIPP_OFF_THROT:  throt <= 11'(merge(32'(throt), w_data, w_strb));
        `SIPP_OFF_BUFLIM: buflim <= 16'(merge(32'(buflim), w_data, w_strb));
        `SIPP_OFF_MCMD: begin
          mcmd <= 10'(merge(32'(mcmd), w_data, w_strb));
          case (w_data[`SIPP_MCMD_TGT])
            `SIPP_TGT_CIR: begin
              if (w_data[`SIPP_MCMD_IDX] < 5'(NS)) begin
                cir[w_data[`SIPP_MCMD_IDX]] <= mval[12:0];
              end
            end
            `SIPP_TGT_CBS: cbs <= mval;
            `SIPP_TGT_EBS: ebs <= mval;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // Classification and the verdict for the packet on the input this cycle.
  always_comb begin
    st_src = tree_ctl[2*PKT.port +: 2];
    case (mcfg[`SIPP_MCFG_MODE])
      `SIPP_MODE_PORT: sid = {3'h0, PKT.port};
      `SIPP_MODE_PRIO: sid = {2'h0, PKT.prio};
      default:         sid = {PKT.port, PKT.prio};
    endcase
    need = {4'h0, PKT.len};
    for (int p = 0; p < NP; p++) begin
      dis_mask[p] = tree_ctl[2*p +: 2] == `SIPP_ST_DIS;
    end
    rx_ok = (st_src == `SIPP_ST_FWD) ||
            (st_src != `SIPP_ST_DIS && PKT.ovr);
    meter_on = mcfg[`SIPP_MCFG_EN] && rx_ok;
    deb_c = PKT_VALID && meter_on && cbk[sid] >= need;
    deb_e = PKT_VALID && meter_on && !deb_c && ebk[sid] >= need;
    // one in four yellow packets dropped
    ydrop = lfsr[1:0] == 2'h0;
    bdrop = PKT.flood && throt[8 + PKT.port] &&
            (bcnt[PKT.port] + need >
             {2'h0, throt[`SIPP_THR_LEVEL], 6'h00});
    bufdrop = PKT.flood && BC_BUF_USED > buflim;
    next_vd.colour = !meter_on ? SIPP_UNMET :
                     deb_c ? SIPP_GREEN :
                     deb_e ? SIPP_YELLOW : SIPP_RED;
    next_vd.fwd = rx_ok && next_vd.colour != SIPP_RED &&
                  !(next_vd.colour == SIPP_YELLOW && ydrop) &&
                  !bdrop && !bufdrop;
    next_vd.learn = st_src == `SIPP_ST_LRN || st_src == `SIPP_ST_FWD;
    for (int p = 0; p < NP; p++) begin
      next_vd.dest[p] = PKT.dest[p] && !dis_mask[p] &&
                        (tree_ctl[2*p +: 2] == `SIPP_ST_FWD || PKT.ovr);
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      VERDICT_VALID <= 1'b0;
      VERDICT       <= '0;
    end else begin
      VERDICT_VALID <= PKT_VALID;
      // The verdict holds between packets, so status shows the last colour.
      if (PKT_VALID) begin
        VERDICT <= next_vd;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt <= 16'h0000;
    end else if (PKT_VALID && !next_vd.fwd && drop_cnt != 16'hFFFF) begin
      drop_cnt <= drop_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= `SIPP_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // Buckets only ever climb to a limit, so a limit below the current fill
  // bites once traffic has drained the bucket under it.
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      tick[i] = pcnt[i] >= period(cir[i]) - 14'h0001;
      next_cbk[i] = cbk[i];
      next_ebk[i] = ebk[i];
      if (tick[i]) begin
        if (cbk[i] < cbs) begin
          next_cbk[i] = cbk[i] + 16'h0001;
        end else if (ebk[i] < ebs) begin
          next_ebk[i] = ebk[i] + 16'h0001;
        end
      end
      if (deb_c && sid == 5'(i)) begin
        next_cbk[i] = next_cbk[i] - need;
      end
      if (deb_e && sid == 5'(i)) begin
        next_ebk[i] = next_ebk[i] - need;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NS; i++) begin
        cbk[i]  <= `SIPP_BUCKET_INIT;
        ebk[i]  <= `SIPP_BUCKET_INIT;
        pcnt[i] <= 14'h0000;
      end
    end else begin
      for (int i = 0; i < NS; i++) begin
        cbk[i]  <= next_cbk[i];
        ebk[i]  <= next_ebk[i];
        pcnt[i] <= tick[i] ? 14'h0000 : pcnt[i] + 14'h0001;
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ivl <= 17'h0_0000;
      for (int p = 0; p < NP; p++) begin
        bcnt[p] <= 16'h0000;
      end
    end else if (ivl >= 17'(THROT_CYC - 1)) begin
      ivl <= 17'h0_0000;
      for (int p = 0; p < NP; p++) begin
        bcnt[p] <= 16'h0000;
      end
      // A packet taken at the boundary opens the new window's count, so
      // its bytes cannot slip past the throttle.
      if (PKT_VALID && PKT.flood && next_vd.fwd) begin
        bcnt[PKT.port] <= need;
      end
    end else begin
      ivl <= ivl + 17'h0_0001;
      if (PKT_VALID && PKT.flood && next_vd.fwd) begin
        bcnt[PKT.port] <= bcnt[PKT.port] + need;
      end
    end
  end

  default clocking cb_clk @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_src_off;
    PKT_VALID && st_src == `SIPP_ST_DIS;
  endsequence

  sequence s_plain_fwd;
    PKT_VALID && tree_ctl == 6'h00 && !mcfg[0] && !PKT.flood;
  endsequence

  a_disabled_rx_drop: assert property (
    s_src_off |=> VERDICT_VALID && !VERDICT.fwd && !VERDICT.learn)
    else $error("packet from disabled port was passed");
  a_tx_disabled_blk: assert property (
    PKT_VALID |=> (VERDICT.dest & $past(dis_mask)) == 3'h0)
    else $error("transmit to disabled port was allowed");
  a_learn_state_gate: assert property (
    PKT_VALID && st_src == `SIPP_ST_BLK |=> !VERDICT.learn)
    else $error("learning in blocking state");
  a_fwd_state_pass: assert property (
    s_plain_fwd |=> VERDICT.fwd && VERDICT.dest == $past(PKT.dest))
    else $error("forwarding port packet was held back");
  a_override_rx_pass: assert property (
    PKT_VALID && st_src == `SIPP_ST_LRN && PKT.ovr && !mcfg[0] &&
    !PKT.flood |=> VERDICT.fwd && VERDICT.learn)
    else $error("override packet dropped in learning state");
  a_unmetered_pass: assert property (
    PKT_VALID && !mcfg[0] |=> VERDICT.colour == SIPP_UNMET)
    else $error("packet coloured while metering off");
  a_red_drop_out: assert property (
    VERDICT_VALID && VERDICT.colour == SIPP_RED |-> !VERDICT.fwd)
    else $error("red packet was forwarded");
  a_green_debit_amt: assert property (
    deb_c && !tick[sid] |=> cbk[$past(sid)] == $past(cbk[sid]) - $past(need))
    else $error("green packet debit wrong");
  a_buf_limit_drop: assert property (
    PKT_VALID && PKT.flood && BC_BUF_USED > buflim |=> !VERDICT.fwd)
    else $error("flood packet passed over buffer limit");

endmodule

`default_nettype wire
